//--- logic/can_msg_params.svh
`ifndef CAN_MSG_PARAMS_SVH
`define CAN_MSG_PARAMS_SVH
// buffer selector digit in address bits 7..4 (window 0x40..0x8f)
`define SEL_RX 4'h4
`define SEL_TX0 4'h5
`define SEL_TX1 4'h6
`define SEL_TX2 4'h7
`define SEL_BG 4'h8
// byte offsets inside one 16-byte buffer
`define OFS_ID0 4'h0
`define OFS_ID3 4'h3
`define OFS_PAY0 4'h4
`define OFS_PAY7 4'hb
`define OFS_LEN 4'hc
`define OFS_PRIO 4'hd
// field positions
`define IDE_BIT 3
`define SRR_BIT 4
`define RTR_STD_BIT 4
`define RTR_EXT_BIT 0
`define DLC_MAX 4'h8
`define FIFO_DEPTH 8
`endif

//--- logic/can_msg_pkg.sv
package can_msg_pkg;
  typedef logic [7:0] byte_t;
  typedef struct packed {
    byte_t [12:0] b;
  } msg_s;
  typedef struct packed {
    logic [7:0] data;
    logic sof;
  } word_s;
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_send = 3'b010,
    st_recv = 3'b100
  } eng_e;
endpackage

//--- logic/can_byte_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module can_byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp;
  logic [AW:0] rp;
  logic full;
  logic empty;
  assign empty = (wp == rp);
  assign full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rp[AW-1:0]];
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (in_valid && !full) wp <= wp + 1'b1;
      if (out_ready && !empty) rp <= rp + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (in_valid && !full) mem[wp[AW-1:0]] <= in_data;
  end
endmodule
`default_nettype wire

//--- logic/can_message_buffer_store.sv
// What this block does
// - all buffers share one 13-byte layout; contents undefined after reset
// - foreground receive buffer readable always; cpu writes ignored
// - transmit buffers readable and writable by cpu at any time
// - address digit 4 selects receive, 5/6/7 select transmit 0/1/2
// - extended identifier layout across four identifier bytes with srr, ide, rtr
// - standard identifier layout in two bytes; rtr bit 4, ide bit 3
// - identifier 11 or 29 bits, most significant bit sent first
// - smaller identifier means higher bus priority
// - srr only extended; software writes 1; received value stored
// - ide 0 standard, 1 extended; captured on receive, chooses format on send
// - rtr 0 data, 1 remote; captured on receive, sent as programmed
// - length code in bits 3..0; codes 0..8 give 0..8 data bytes
// - remote frame sends programmed length code but no payload bytes
// - eight payload registers; only length-code count sent; receive fills every arriving payload byte, up to eight
// - transmit buffers carry local priority byte at offset d; receive none
// - just before start of frame, queued transmit buffers join prioritisation
// - lowest local priority value wins
// - ties go to lowest buffer index
// - each buffer takes 16 bytes; last two unused
// - background receive buffer readable only in test mode
`timescale 1ns/1ps
`default_nettype none
`include "can_msg_params.svh"
module can_message_buffer_store #(
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  // cpu register port
  input wire logic [7:0] cpu_addr,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  input wire logic test_mode,
  // queue control: each bit set means buffer free
  input wire logic [2:0] tx_buffer_empty_flag,
  // protocol engine: start of frame request and transmit stream
  input wire logic sof_request,
  output logic tx_grant_valid,
  output logic [1:0] tx_grant_index,
  output logic tx_none,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  output logic tx_first,
  input wire logic tx_ready,
  // protocol engine: receive stream into background buffer
  input wire logic rx_valid,
  input wire logic rx_first,
  input wire logic [7:0] rx_byte,
  output logic rx_ready,
  input wire logic rx_commit
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    can_msg_pkg::msg_s [3:0] buf_mem;
    can_msg_pkg::msg_s bg;
    can_msg_pkg::byte_t [2:0] prio;
    can_msg_pkg::eng_e eng;
    logic [1:0] sel;
    logic [3:0] pos;
    logic [3:0] last;
    logic [3:0] rpos;
    logic [7:0] rdata;
    logic grant_valid;
    logic [1:0] grant_index;
    logic none;
    logic fout_valid;
    logic [7:0] fout_byte;
    logic fout_first;
    logic rx_ready_q;
  } state_s;
  state_s q;
  state_s d;

  logic f_in_valid;
  logic f_in_ready;
  can_msg_pkg::word_s f_in;
  logic f_out_valid;
  logic f_out_ready;
  can_msg_pkg::word_s f_out;

  // transmit bytes pass through a fifo so engine back-pressure stalls the reader
  can_byte_fifo #(
    .WIDTH(9),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(f_in),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out)
  );

  // output register is a one-entry skid: refill when empty or consumed
  assign f_out_ready = !q.fout_valid || tx_ready;

  // ****************************************
  // helpers
  // ****************************************
  // frame byte count: identifier bytes + payload, from the format bits
  function automatic logic [3:0] frame_last(input can_msg_pkg::msg_s m);
    logic ext;
    logic rtr;
    logic [3:0] dlc;
    logic [3:0] n;
    ext = m.b[`OFS_ID0 + 1][`IDE_BIT];
    rtr = ext ? m.b[`OFS_ID3][`RTR_EXT_BIT] : m.b[`OFS_ID0 + 1][`RTR_STD_BIT];
    dlc = m.b[`OFS_LEN][3:0];
    n = rtr ? 4'h0 : ((dlc > `DLC_MAX) ? `DLC_MAX : dlc);
    // standard format uses only two identifier bytes, yet layout stays fixed
    frame_last = `OFS_PAY0 + n;
  endfunction

  logic [1:0] win;
  logic any;
  always_comb begin
    win = 2'h0;
    any = 1'b0;
    // strict less-than keeps the lower index on ties
    for (int i = 0; i < 3; i++) begin
      if (!tx_buffer_empty_flag[i]) begin
        if (!any || q.prio[i] < q.prio[win]) begin
          win = 2'(i);
          any = 1'b1;
        end
      end
    end
  end

  // ****************************************
  // next state
  // ****************************************
  logic [3:0] sel_digit;
  logic [3:0] ofs;
  logic [3:0] bpos;
  assign sel_digit = cpu_addr[7:4];
  assign ofs = cpu_addr[3:0];

  always_comb begin
    d = q;
    f_in_valid = 1'b0;
    f_in = '0;
    bpos = 4'h0;
    d.grant_valid = 1'b0;
    // cpu read, registered: answer one cycle after cpu_rd
    if (cpu_rd) begin
      d.rdata = 8'h00;
      if (sel_digit >= `SEL_RX && sel_digit <= `SEL_TX2) begin
        if (ofs <= `OFS_LEN) begin
          d.rdata = q.buf_mem[sel_digit - `SEL_RX].b[ofs];
        end else if (ofs == `OFS_PRIO && sel_digit != `SEL_RX) begin
          d.rdata = q.prio[sel_digit - `SEL_TX0];
        end
      end else if (sel_digit == `SEL_BG && test_mode && ofs <= `OFS_LEN) begin
        d.rdata = q.bg.b[ofs];
      end
    end
    // cpu write: transmit buffers only, any time; receive buffer ignores it
    if (cpu_wr && sel_digit >= `SEL_TX0 && sel_digit <= `SEL_TX2) begin
      if (ofs <= `OFS_LEN) begin
        d.buf_mem[sel_digit - `SEL_RX].b[ofs] = cpu_wdata;
      end else if (ofs == `OFS_PRIO) begin
        d.prio[sel_digit - `SEL_TX0] = cpu_wdata;
      end
    end
    // transmit skid register
    if (f_out_ready) begin
      d.fout_valid = f_out_valid;
      d.fout_byte = f_out.data;
      d.fout_first = f_out.sof;
    end
    d.rx_ready_q = 1'b0;
    case (q.eng)
      can_msg_pkg::st_idle: begin
        d.rx_ready_q = 1'b1;
        if (sof_request) begin
          d.grant_valid = 1'b1;
          d.none = !any;
          d.grant_index = win;
          if (any) begin
            d.sel = win;
            d.pos = 4'h0;
            d.last = frame_last(q.buf_mem[win + 2'h1]);
            d.eng = can_msg_pkg::st_send;
          end
        end else if (rx_valid && rx_first) begin
          d.bg.b[0] = rx_byte;
          d.rpos = 4'h1;
          d.eng = can_msg_pkg::st_recv;
        end
      end
      can_msg_pkg::st_send: begin
        // identifier bytes then payload, msb first within each byte
        f_in_valid = 1'b1;
        bpos = (q.pos == q.last) ? `OFS_LEN : q.pos;
        f_in.data = q.buf_mem[q.sel + 2'h1].b[bpos];
        f_in.sof = (q.pos == 4'h0);
        if (f_in_ready) begin
          if (q.pos == q.last) d.eng = can_msg_pkg::st_idle;
          else d.pos = q.pos + 4'h1;
        end
      end
      can_msg_pkg::st_recv: begin
        d.rx_ready_q = 1'b1;
        // bytes arrive id0..id3, length, then payload, up to eight bytes whatever the code
        if (rx_valid && q.rpos <= `OFS_LEN) begin
          if (q.rpos < `OFS_PAY0) d.bg.b[q.rpos] = rx_byte;
          else if (q.rpos == `OFS_PAY0) d.bg.b[`OFS_LEN] = rx_byte;
          else d.bg.b[q.rpos - 4'h1] = rx_byte;
          d.rpos = q.rpos + 4'h1;
        end
        if (rx_commit) begin
          d.buf_mem[0] = d.bg;
          d.eng = can_msg_pkg::st_idle;
        end
      end
      default: d.eng = can_msg_pkg::st_idle;
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  // buffer contents are left out of reset on purpose: undefined by design
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q.eng <= can_msg_pkg::st_idle;
      q.sel <= 2'h0;
      q.pos <= 4'h0;
      q.last <= 4'h0;
      q.rpos <= 4'h0;
      q.rdata <= 8'h00;
      q.grant_valid <= 1'b0;
      q.grant_index <= 2'h0;
      q.none <= 1'b1;
      q.fout_valid <= 1'b0;
      q.fout_byte <= 8'h00;
      q.fout_first <= 1'b0;
      q.rx_ready_q <= 1'b0;
    end else begin
      // buffers simply hold through reset, so they keep no defined value
      q <= d;
    end
  end

  assign cpu_rdata = q.rdata;
  assign tx_grant_valid = q.grant_valid;
  assign tx_grant_index = q.grant_index;
  assign tx_none = q.none;
  assign tx_valid = q.fout_valid;
  assign tx_byte = q.fout_byte;
  assign tx_first = q.fout_first;
  assign rx_ready = q.rx_ready_q;
endmodule
`default_nettype wire

//--- dv/can_store_chk.sv
`timescale 1ns/1ps
`default_nettype none
module can_store_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] cpu_addr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_rdata,
  input wire logic test_mode,
  input wire logic [2:0] tx_buffer_empty_flag,
  input wire logic sof_request,
  input wire logic tx_grant_valid,
  input wire logic [1:0] tx_grant_index,
  input wire logic tx_none,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_ready
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic [2:0] prev_empty;
  always_ff @(posedge clk) prev_empty <= tx_buffer_empty_flag;
  sequence s_grant;
    sof_request ##1 tx_grant_valid;
  endsequence
  sequence s_stall;
    tx_valid && !tx_ready;
  endsequence
  grant_has_cause_a: assert property (tx_grant_valid |-> $past(sof_request))
    else $error("grant without request");
  none_when_free_a: assert property (s_grant |-> tx_none == &prev_empty)
    else $error("no-queue flag wrong");
  winner_queued_a: assert property (s_grant ##0 !tx_none |-> !prev_empty[tx_grant_index])
    else $error("winner not queued");
  stream_hold_a: assert property (s_stall |=> tx_valid && $stable(tx_byte))
    else $error("stalled byte changed");
  read_hold_a: assert property (!cpu_rd |=> $stable(cpu_rdata))
    else $error("read data moved");
  hole_zero_a: assert property (cpu_rd && (cpu_addr[7:4] < 4'h4 || cpu_addr[3:1] == 3'h7) |=> !cpu_rdata)
    else $error("unused place not zero");
  rx_no_prio_a: assert property (cpu_rd && cpu_addr == 8'h4d |=> !cpu_rdata)
    else $error("rx priority not zero");
  bg_locked_a: assert property (cpu_rd && cpu_addr[7:4] == 4'h8 && !test_mode |=> !cpu_rdata)
    else $error("background readable");
endmodule
bind can_message_buffer_store can_store_chk i_chk (.clk, .sys_rst, .cpu_addr, .cpu_rd, .cpu_rdata, .test_mode,
  .tx_buffer_empty_flag, .sof_request, .tx_grant_valid, .tx_grant_index, .tx_none, .tx_valid, .tx_byte, .tx_ready);
`default_nettype wire

//--- dv/can_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module can_engine_model (
  input wire logic clk,
  input wire logic stall,
  input wire logic sof_request,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_first,
  output logic tx_ready,
  output logic [15:0] got_first,
  output logic [7:0] got [0:15],
  output int got_n
);
  logic [1:0] cnt = 2'h0;
  initial tx_ready = 1'h0;
  initial got_n = 0;
  // slow mode takes one byte in four so the fifo backs up
  always @(posedge clk) begin
    cnt <= cnt + 2'h1;
    tx_ready <= !stall || cnt == 2'h0;
    if (sof_request)
      got_n <= 0;
    else if (tx_valid && tx_ready) begin
      got[got_n[3:0]] <= tx_byte;
      got_first[got_n[3:0]] <= tx_first;
      got_n <= got_n + 1;
    end
  end
endmodule
`default_nettype wire

//--- dv/can_message_buffer_store_tb.sv
`timescale 1ns/1ps
`default_nettype none
module can_message_buffer_store_tb;
  logic clk = '0, sys_rst = '1, cpu_rd = '0, cpu_wr = '0, test_mode = '0, sof_request = '0, stall = '0;
  logic rx_valid = '0, rx_first = '0, rx_commit = '0;
  logic [7:0] cpu_addr = '0, cpu_wdata = '0, rx_byte = '0, cpu_rdata, tx_byte;
  logic [2:0] tx_buffer_empty_flag = 3'h7;
  logic [1:0] tx_grant_index;
  logic tx_grant_valid, tx_none, tx_valid, tx_first, tx_ready, rx_ready;
  logic [7:0] got [0:15];
  logic [15:0] got_first;
  logic [7:0] id1 [3] = '{8'h20, 8'h30, 8'h20};
  logic [7:0] dlc [3] = '{8'h08, 8'h05, 8'h02};
  logic [7:0] rxf [8] = '{8'ha5, 8'h1b, 8'h3c, 8'h7e, 8'h03, 8'h11, 8'h22, 8'h33};
  int got_n, n_errors = 0, cmp_count = 0, cyc = 0;
  can_message_buffer_store i_dut (.clk, .sys_rst, .cpu_addr, .cpu_rd, .cpu_wr, .cpu_wdata, .cpu_rdata, .test_mode,
    .tx_buffer_empty_flag, .sof_request, .tx_grant_valid, .tx_grant_index, .tx_none, .tx_valid, .tx_byte, .tx_first,
    .tx_ready, .rx_valid, .rx_first, .rx_byte, .rx_ready, .rx_commit);
  can_engine_model i_eng (.clk, .stall, .sof_request, .tx_valid, .tx_byte, .tx_first, .tx_ready, .got_first, .got,
    .got_n);
  initial forever #25 clk = ~clk;
  // ********
  // tasks
  // ********
  function automatic logic [7:0] val(input int b, input int o);
    return o == 1 ? id1[b] : o == 12 ? dlc[b] : o == 13 ? (b == 2 ? 8'h10 : 8'h40) : {4'(b + 5), 4'(o)};
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'h1;
    @(negedge clk);
    cpu_wr = 1'h0;
    @(negedge clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    cpu_addr = a;
    cpu_rd = 1'h1;
    @(negedge clk);
    cpu_rd = 1'h0;
    @(negedge clk);
    chk($sformatf("rdata %h", a), e, cpu_rdata);
  endtask
  // remote frames carry no payload, so n drops to zero for them
  task automatic send(input logic [2:0] fl, input int b);
    int n;
    n = b < 0 ? -5 : id1[b][4] ? 0 : dlc[b];
    tx_buffer_empty_flag = fl;
    sof_request = 1'h1;
    @(negedge clk);
    sof_request = 1'h0;
    for (int k = 0; k < 4 && tx_grant_valid !== 1'h1; k++) @(negedge clk);
    chk("grant", 8'h01, 8'(tx_grant_valid));
    chk("none", 8'(b < 0), 8'(tx_none));
    if (b >= 0) begin
      chk("index", 8'(b), 8'(tx_grant_index));
      @(negedge clk);
      chk("rx_ready", 8'h00, 8'(rx_ready));
    end
    for (int k = 0; k < 200 && got_n < n + 5; k++) @(negedge clk);
    repeat (4) @(negedge clk);
    chk("count", 8'(n + 5), 8'(got_n));
    for (int i = 0; i < n + 5; i++) begin
      chk("byte", i < n + 4 ? val(b, i) : dlc[b], got[i]);
      chk("first", 8'(i == 0), 8'(got_first[i]));
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (12) @(negedge clk);
    sys_rst = 1'h0;
    for (int i = 0; i < 42; i++) wr({4'(i / 14 + 5), 4'(i % 14)}, val(i / 14, i % 14));
    for (int i = 0; i < 42; i++) rc({4'(i / 14 + 5), 4'(i % 14)}, val(i / 14, i % 14));
    wr(8'h5e, 8'hff);
    rc(8'h5e, 8'h00);
    rc(8'h30, 8'h00);
    $display("register test done");
    for (int i = 0; i < 8; i++) begin
      rx_valid = 1'h1;
      rx_first = i == 0;
      rx_byte = rxf[i];
      while (rx_ready !== 1'h1) @(negedge clk);
      @(negedge clk);
    end
    rx_valid = 1'h0;
    rx_commit = 1'h1;
    @(negedge clk);
    rx_commit = 1'h0;
    for (int i = 0; i < 8; i++) rc(8'h40 + 8'(i < 4 ? i : i == 4 ? 12 : i - 1), rxf[i]);
    wr(8'h40, 8'h00);
    rc(8'h40, 8'ha5);
    rc(8'h4d, 8'h00);
    rc(8'h80, 8'h00);
    test_mode = 1'h1;
    rc(8'h80, 8'ha5);
    test_mode = 1'h0;
    $display("receive test done");
    send(3'h0, 2);
    stall = 1'h1;
    send(3'h4, 0);
    stall = 1'h0;
    send(3'h5, 1);
    send(3'h7, -1);
    $display("transmit test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
